// >>> verilog/ilc_top.sv
// in-band loop code generator, three detectors and register port
`timescale 1ns/1ps
`include "ilc_regs.svh"
module ilc_top #(
  parameter int unsigned INTEG_CYCLES = `ILC_INTEG_MS * `ILC_CLK_KHZ
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic T1_MODE,
  input wire logic TX_LOOP_EN,
  input wire logic TX_FBIT_INS_DIS,
  input wire logic TX_BIT_EN,
  input wire logic TX_FBIT_POS,
  input wire logic TX_DATA_IN,
  output logic TX_DATA_OUT,
  input wire logic RX_LINE_CLK,
  input wire logic RX_LINE_DATA,
  output logic LOOP_UP_DET,
  output logic LOOP_DOWN_DET,
  output logic SPARE_DET
);

  // ****************************************************
  // declarations
  // ****************************************************
  ilc_pkg::ilc_top_t s_q;
  ilc_pkg::ilc_top_t s_d;
  logic [1:0] rx_sync;
  logic up_det;
  logic dn_det;
  logic sp_det;
  logic up_restart;
  logic dn_restart;
  logic sp_restart;
  logic tx_active;
  logic tx_fbit;
  logic [4:0] tx_len;
  logic [7:0] status;

  // ****************************************************
  // receive line synchroniser
  // ****************************************************
  // the line clock and data come from another domain
  ilc_sync u_sync (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .d({RX_LINE_DATA, RX_LINE_CLK}),
    .q(rx_sync)
  );

  // ****************************************************
  // restart strobes
  // ****************************************************
  // either byte of a detector's code restarts its window
  assign up_restart = REG_WR && (REG_ADDR == `ILC_OFS_UP_HI ||
                      REG_ADDR == `ILC_OFS_UP_LO); // [RULE15]
  assign dn_restart = REG_WR && (REG_ADDR == `ILC_OFS_DN_HI ||
                      REG_ADDR == `ILC_OFS_DN_LO); // [RULE15]
  assign sp_restart = REG_WR && (REG_ADDR == `ILC_OFS_SP_HI ||
                      REG_ADDR == `ILC_OFS_SP_LO); // [RULE15]

  // ****************************************************
  // transmit decode
  // ****************************************************
  assign tx_active = T1_MODE && TX_LOOP_EN; // [RULE1] [RULE5]
  assign tx_fbit = TX_FBIT_POS && !TX_FBIT_INS_DIS; // [RULE6]
  assign tx_len = ilc_pkg::ilc_tx_len(
    s_q.ctrl[`ILC_TXLEN_MSB:`ILC_TXLEN_LSB]); // [RULE3]

  // status bits sit where the framer keeps them
  always_comb begin
    status = 8'h00;
    status[`ILC_ST_UP_BIT] = up_det;
    status[`ILC_ST_DN_BIT] = dn_det;
    status[`ILC_ST_SP_BIT] = sp_det;
  end

  // ****************************************************
  // next-state logic
  // ****************************************************
  always_comb begin
    s_d = s_q;
    // register writes; spare control bits 7:3 are dropped, not stored
    if (REG_WR) begin
      case (REG_ADDR)
        `ILC_OFS_CTRL: s_d.ctrl = REG_WDATA;
        `ILC_OFS_TX_HI: s_d.tx_hi = REG_WDATA;
        `ILC_OFS_TX_LO: s_d.tx_lo = REG_WDATA;
        `ILC_OFS_UP_HI: s_d.up_hi = REG_WDATA;
        `ILC_OFS_UP_LO: s_d.up_lo = REG_WDATA;
        `ILC_OFS_DN_HI: s_d.dn_hi = REG_WDATA;
        `ILC_OFS_DN_LO: s_d.dn_lo = REG_WDATA;
        `ILC_OFS_SP_CTRL: begin
          s_d.sp_ctrl = REG_WDATA[`ILC_SPLEN_MSB:0]; // [RULE18]
        end
        `ILC_OFS_SP_HI: s_d.sp_hi = REG_WDATA;
        `ILC_OFS_SP_LO: s_d.sp_lo = REG_WDATA;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // read data is captured so it holds until the next read
    if (REG_RD) begin
      case (REG_ADDR)
        `ILC_OFS_CTRL: s_d.rdata = s_q.ctrl;
        `ILC_OFS_TX_HI: s_d.rdata = s_q.tx_hi;
        `ILC_OFS_TX_LO: s_d.rdata = s_q.tx_lo;
        `ILC_OFS_UP_HI: s_d.rdata = s_q.up_hi;
        `ILC_OFS_UP_LO: s_d.rdata = s_q.up_lo;
        `ILC_OFS_DN_HI: s_d.rdata = s_q.dn_hi;
        `ILC_OFS_DN_LO: s_d.rdata = s_q.dn_lo;
        `ILC_OFS_SP_CTRL: s_d.rdata = {5'h00, s_q.sp_ctrl};
        `ILC_OFS_SP_HI: s_d.rdata = s_q.sp_hi;
        `ILC_OFS_SP_LO: s_d.rdata = s_q.sp_lo;
        `ILC_OFS_STATUS: s_d.rdata = status;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // transmit: pattern bit per line bit, framing slot overwritten
    if (!tx_active) begin
      s_d.tx_phase = 5'h00;
      if (TX_BIT_EN) s_d.tx_out = TX_DATA_IN;
    end else if (TX_BIT_EN) begin
      s_d.tx_out = tx_fbit ? TX_DATA_IN : // [RULE6]
        ilc_pkg::ilc_code_bit(s_q.tx_hi, s_q.tx_lo,
                              s_q.tx_phase); // [RULE7] [RULE5]
      // overwrite keeps the phase running through the framing slot
      s_d.tx_phase = ilc_pkg::ilc_next(s_q.tx_phase, tx_len,
                                       5'h01); // [RULE2] [RULE3]
    end
    // receive: a rising line clock takes one bit
    s_d.rx_clk_prev = rx_sync[0];
    s_d.rx_bit_en = rx_sync[0] && !s_q.rx_clk_prev;
    s_d.rx_bit = rx_sync[1];
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // detectors
  // ****************************************************
  // three independent detectors share one design
  ilc_detect #(.WIN_CYCLES(INTEG_CYCLES)) u_up ( // [RULE8]
    .clk(CLK_SYS),
    .rstn(RSTN),
    .en(T1_MODE),
    .restart(up_restart),
    .len_code(s_q.ctrl[`ILC_UPLEN_MSB:`ILC_UPLEN_LSB]), // [RULE9]
    .code_hi(s_q.up_hi),
    .code_lo(s_q.up_lo),
    .bit_en(s_q.rx_bit_en),
    .bit_in(s_q.rx_bit),
    .detected(up_det)
  );

  ilc_detect #(.WIN_CYCLES(INTEG_CYCLES)) u_dn ( // [RULE8]
    .clk(CLK_SYS),
    .rstn(RSTN),
    .en(T1_MODE),
    .restart(dn_restart),
    .len_code(s_q.ctrl[`ILC_DNLEN_MSB:`ILC_DNLEN_LSB]), // [RULE10]
    .code_hi(s_q.dn_hi),
    .code_lo(s_q.dn_lo),
    .bit_en(s_q.rx_bit_en),
    .bit_in(s_q.rx_bit),
    .detected(dn_det)
  );

  ilc_detect #(.WIN_CYCLES(INTEG_CYCLES)) u_sp ( // [RULE8]
    .clk(CLK_SYS),
    .rstn(RSTN),
    .en(T1_MODE),
    .restart(sp_restart),
    .len_code(s_q.sp_ctrl), // [RULE18]
    .code_hi(s_q.sp_hi),
    .code_lo(s_q.sp_lo),
    .bit_en(s_q.rx_bit_en),
    .bit_in(s_q.rx_bit),
    .detected(sp_det)
  );

  // ****************************************************
  // outputs
  // ****************************************************
  assign REG_RDATA = s_q.rdata;
  assign TX_DATA_OUT = s_q.tx_out;
  assign LOOP_UP_DET = up_det;
  assign LOOP_DOWN_DET = dn_det;
  assign SPARE_DET = sp_det;

endmodule // ilc_top

// >>> verilog/ilc_regs.svh
// register offsets, field positions, reset values and timing counts
// Functional notes
// [RULE1] loop code function works in T1 mode only
// [RULE2] code lengths one to eight or sixteen
// [RULE3] transmit length field bits 7:6 picks length
// [RULE4] host fills code registers per length
// [RULE5] code sent while transmit enable stays set
// [RULE6] framing bit overwrites code every 193 bits
// [RULE7] transmit code starts at bit 7, high register
// [RULE8] three detectors: up, down and spare
// [RULE9] up length field bits 5:3 picks length
// [RULE10] down length field bits 2:0 picks length
// [RULE11] sixteen-bit codes use both code registers
// [RULE12] host loads same byte twice for eight bits
// [RULE13] receive code starts at bit 7, high register
// [RULE14] detect framed or unframed, tolerate errors
// [RULE15] code register write restarts integration
// [RULE16] status set after 36ms valid code
// [RULE17] host polls status while code persists
// [RULE18] spare length field bits 2:0, rest zero
`ifndef ILC_REGS_SVH
`define ILC_REGS_SVH

// ****************************************************
// register offsets
// ****************************************************
`define ILC_OFS_CTRL 8'hB6
`define ILC_OFS_TX_HI 8'hB7
`define ILC_OFS_TX_LO 8'hB8
`define ILC_OFS_UP_HI 8'hB9
`define ILC_OFS_UP_LO 8'hBA
`define ILC_OFS_DN_HI 8'hBB
`define ILC_OFS_DN_LO 8'hBC
`define ILC_OFS_SP_CTRL 8'hBD
`define ILC_OFS_SP_HI 8'hBE
`define ILC_OFS_SP_LO 8'hBF
`define ILC_OFS_STATUS 8'hC0

// ****************************************************
// fields and reset values
// ****************************************************
`define ILC_TXLEN_MSB 7
`define ILC_TXLEN_LSB 6
`define ILC_UPLEN_MSB 5
`define ILC_UPLEN_LSB 3
`define ILC_DNLEN_MSB 2
`define ILC_DNLEN_LSB 0
`define ILC_SPLEN_MSB 2
`define ILC_ST_UP_BIT 5
`define ILC_ST_DN_BIT 6
`define ILC_ST_SP_BIT 7
`define ILC_RST_VAL 8'h00

// ****************************************************
// timing
// ****************************************************
`define ILC_INTEG_MS 36
`define ILC_CLK_KHZ 200000
`define ILC_ERR_SHIFT 4
`define ILC_SLIP_LIMIT 4'h4

`endif

// >>> verilog/ilc_pkg.sv
// types and helper functions of the in-band loop code block
package ilc_pkg;

  // ****************************************************
  // state records
  // ****************************************************
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ilc_sync_t;

  typedef struct packed {
    logic [4:0] phase;
    logic [7:0] hist;
    logic [23:0] win;
    logic [16:0] nbits;
    logic [16:0] nerrs;
    logic det;
  } ilc_det_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] tx_hi;
    logic [7:0] tx_lo;
    logic [7:0] up_hi;
    logic [7:0] up_lo;
    logic [7:0] dn_hi;
    logic [7:0] dn_lo;
    logic [2:0] sp_ctrl;
    logic [7:0] sp_hi;
    logic [7:0] sp_lo;
    logic [7:0] rdata;
    logic [4:0] tx_phase;
    logic tx_out;
    logic rx_clk_prev;
    logic rx_bit;
    logic rx_bit_en;
  } ilc_top_t;

  // ****************************************************
  // functions
  // ****************************************************
  // receive length: 1..7, and 16 for the 8/16 code
  function automatic logic [4:0] ilc_rx_len(input logic [2:0] c);
    ilc_rx_len = (c == 3'h7) ? 5'h10 : {2'h0, c} + 5'h01;
  endfunction

  // transmit length: 5, 6 (or 3), 7, 16 (or 8/4/2/1)
  function automatic logic [4:0] ilc_tx_len(input logic [1:0] c);
    case (c)
      2'h0: ilc_tx_len = 5'h05;
      2'h1: ilc_tx_len = 5'h06;
      2'h2: ilc_tx_len = 5'h07;
      default: ilc_tx_len = 5'h10;
    endcase
  endfunction

  // phase 0 is bit 7 of the high byte, phase 8 bit 7 of the low
  function automatic logic ilc_code_bit(input logic [7:0] hi,
                                        input logic [7:0] lo,
                                        input logic [4:0] p);
    ilc_code_bit = p[3] ? lo[~p[2:0]] : hi[~p[2:0]];
  endfunction

  // advance a pattern phase by step, wrapping at len
  function automatic logic [4:0] ilc_next(input logic [4:0] p,
                                          input logic [4:0] len,
                                          input logic [4:0] step);
    logic [4:0] s;
    s = p + step;
    if (s >= len) s = s - len;
    if (s >= len) s = s - len;
    ilc_next = s;
  endfunction

  function automatic logic [3:0] ilc_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) n = n + {3'h0, v[i]};
    ilc_ones = n;
  endfunction

endpackage

// >>> verilog/ilc_sync.sv
// two-stage synchroniser for the receive line clock and data
`timescale 1ns/1ps
module ilc_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] d,
  output logic [1:0] q
);
  ilc_pkg::ilc_sync_t s_q;
  ilc_pkg::ilc_sync_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule // ilc_sync

// >>> verilog/ilc_detect.sv
// one repeating-code detector with phase search and integration
`timescale 1ns/1ps
`include "ilc_regs.svh"
module ilc_detect #(
  parameter int unsigned WIN_CYCLES = 7200000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic restart,
  input wire logic [2:0] len_code,
  input wire logic [7:0] code_hi,
  input wire logic [7:0] code_lo,
  input wire logic bit_en,
  input wire logic bit_in,
  output logic detected
);
  ilc_pkg::ilc_det_t s_q;
  ilc_pkg::ilc_det_t s_d;
  logic [4:0] len;
  logic miss;
  logic slip;

  // compare each line bit to the code at the running phase; a burst
  // of misses slips the phase one bit, which re-aligns after an
  // inserted framing bit, while an overwritten one is a lone miss
  always_comb begin
    s_d = s_q;
    len = ilc_pkg::ilc_rx_len(len_code); // [RULE2] [RULE11]
    miss = bit_in ^ ilc_pkg::ilc_code_bit(code_hi, code_lo,
                                          s_q.phase); // [RULE13]
    slip = 1'b0;
    if (!en || restart) begin
      s_d = '0; // [RULE1] [RULE15]
    end else begin
      if (bit_en) begin
        s_d.hist = {s_q.hist[6:0], miss};
        slip = ilc_pkg::ilc_ones(s_d.hist) >= `ILC_SLIP_LIMIT;
        if (slip) begin
          s_d.phase = ilc_pkg::ilc_next(s_q.phase, len, 5'h02);
          s_d.hist = 8'h00; // [RULE14]
        end else begin
          s_d.phase = ilc_pkg::ilc_next(s_q.phase, len, 5'h01);
        end
        if (s_q.nbits != 17'h1FFFF) s_d.nbits = s_q.nbits + 17'h1;
        if (miss && s_q.nerrs != 17'h1FFFF) begin
          s_d.nerrs = s_q.nerrs + 17'h1;
        end
      end
      // at the end of each window the error share decides the status
      if (s_q.win == 24'(WIN_CYCLES - 1)) begin
        s_d.det = (s_d.nbits != 17'h0) &&
                  ((21'(s_d.nerrs) << `ILC_ERR_SHIFT) <=
                   21'(s_d.nbits)); // [RULE16] [RULE14]
        s_d.win = 24'h0;
        s_d.nbits = 17'h0;
        s_d.nerrs = 17'h0;
      end else begin
        s_d.win = s_q.win + 24'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign detected = s_q.det;
endmodule // ilc_detect

// >>> bench/ilc_props.sv
// port assertions of the in-band loop code block
`timescale 1ns/1ps
module ilc_props (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic T1_MODE,
  input wire logic TX_LOOP_EN,
  input wire logic TX_FBIT_INS_DIS,
  input wire logic TX_BIT_EN,
  input wire logic TX_FBIT_POS,
  input wire logic TX_DATA_IN,
  input wire logic TX_DATA_OUT,
  input wire logic LOOP_UP_DET,
  input wire logic LOOP_DOWN_DET,
  input wire logic SPARE_DET
);
  // ****************************************************
  // transmit and status relations
  // ****************************************************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // code only goes out in t1 mode with the loop enabled
  pass_thru_a: assert property (
    TX_BIT_EN && !(T1_MODE && TX_LOOP_EN) |=>
    TX_DATA_OUT == $past(TX_DATA_IN)) else $error("tx pass-through wrong");
  fbit_over_a: assert property (
    TX_BIT_EN && T1_MODE && TX_LOOP_EN && TX_FBIT_POS && !TX_FBIT_INS_DIS
    |=> TX_DATA_OUT == $past(TX_DATA_IN))
    else $error("framing bit not inserted");
  tx_hold_a: assert property (!TX_BIT_EN |=> $stable(TX_DATA_OUT))
    else $error("tx bit moved without a bit time");
  t1_off_a: assert property (!T1_MODE ##1 !T1_MODE |->
    !LOOP_UP_DET && !LOOP_DOWN_DET && !SPARE_DET)
    else $error("status outside t1");
  // a write two cycles back restarts integration, so status cannot be set yet
  up_restart_a: assert property (REG_WR && (REG_ADDR == 8'hB9 ||
    REG_ADDR == 8'hBA) |-> ##2 !LOOP_UP_DET)
    else $error("up not restarted");
  dn_restart_a: assert property (REG_WR && (REG_ADDR == 8'hBB ||
    REG_ADDR == 8'hBC) |-> ##2 !LOOP_DOWN_DET)
    else $error("down not restarted");
  sp_restart_a: assert property (REG_WR && (REG_ADDR == 8'hBE ||
    REG_ADDR == 8'hBF) |-> ##2 !SPARE_DET)
    else $error("spare not restarted");
  det_in_t1_a: assert property (
    $rose(LOOP_UP_DET) || $rose(LOOP_DOWN_DET) || $rose(SPARE_DET)
    |-> T1_MODE && $past(T1_MODE)) else $error("status rose");
  sp_ctrl_rd_a: assert property (
    REG_RD && REG_ADDR == 8'hBD ##1 !REG_RD |-> ##1 REG_RDATA[7:3] == 5'h00)
    else $error("spare control high bits");
  // main scenarios reached
  up_seen_c: cover property ($rose(LOOP_UP_DET));
  dn_seen_c: cover property ($rose(LOOP_DOWN_DET));
  sp_seen_c: cover property ($rose(SPARE_DET));
  fbit_c: cover property (TX_BIT_EN && TX_FBIT_POS && TX_LOOP_EN);
endmodule // ilc_props

bind ilc_top ilc_props u_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .T1_MODE(T1_MODE), .TX_LOOP_EN(TX_LOOP_EN),
  .TX_FBIT_INS_DIS(TX_FBIT_INS_DIS), .TX_BIT_EN(TX_BIT_EN),
  .TX_FBIT_POS(TX_FBIT_POS), .TX_DATA_IN(TX_DATA_IN),
  .TX_DATA_OUT(TX_DATA_OUT), .LOOP_UP_DET(LOOP_UP_DET),
  .LOOP_DOWN_DET(LOOP_DOWN_DET), .SPARE_DET(SPARE_DET));

// >>> bench/ilc_line_model.sv
// line side model: sends a repeating code with framing overwrite
`timescale 1ns/1ps
module ilc_line_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic [4:0] len,
  input wire logic [15:0] pat,
  output logic line_clk,
  output logic line_data
);
  logic [2:0] cyc;
  logic [4:0] ph;
  logic [7:0] fc;
  logic cbit;
  assign cbit = pat[4'hF - ph[3:0]];
  // ****************************************************
  // bit sender
  // ****************************************************
  // data moves at the line clock fall, four cycles clear of each rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {cyc, ph, fc, line_clk, line_data} <= '0;
    end else if (!en) begin
      cyc <= 3'h0;
      line_clk <= 1'b0; // clock stands still outside bursts
      line_data <= ~line_data; // no stale value on an idle line
    end else begin
      cyc <= cyc + 3'h1;
      line_clk <= cyc[2];
      if (cyc == 3'h0) begin
        line_data <= (fc == 8'hC0) ? ~cbit : cbit;
        fc <= (fc == 8'hC0) ? 8'h00 : fc + 8'h01;
        ph <= (ph + 5'h01 >= len) ? 5'h00 : ph + 5'h01;
      end
    end
  end
endmodule // ilc_line_model

// >>> bench/tb_top.sv
// self-checking bench of the in-band loop code block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } ilc_row_t;
  logic CLK_SYS, RSTN, REG_WR, REG_RD, T1_MODE, TX_LOOP_EN, TX_FBIT_INS_DIS;
  logic TX_BIT_EN, TX_FBIT_POS, TX_DATA_IN, TX_DATA_OUT, RX_LINE_CLK;
  logic RX_LINE_DATA, LOOP_UP_DET, LOOP_DOWN_DET, SPARE_DET, line_en, p, f;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, rd;
  logic [4:0] line_len;
  logic [15:0] line_pat, tx_pat;
  int errors, n_compared;
  // address, written value, value read back
  ilc_row_t regs [11] = '{'{8'hB6, 8'h27, 8'h27}, '{8'hB7, 8'h80, 8'h80},
    '{8'hB8, 8'h5A, 8'h5A}, '{8'hB9, 8'h80, 8'h80}, '{8'hBA, 8'h00, 8'h00},
    '{8'hBB, 8'hCC, 8'hCC}, '{8'hBC, 8'hCC, 8'hCC}, '{8'hBD, 8'hFF, 8'h07},
    '{8'hBE, 8'hA5, 8'hA5}, '{8'hBF, 8'h3C, 8'h3C}, '{8'hC5, 8'hFF, 8'h00}};
  logic [7:0] tx_ctl [4] = '{8'h27, 8'h67, 8'hA7, 8'hE7};
  logic [15:0] tx_cd [4] = '{16'h8000, 16'hB400, 16'h9600, 16'hA53C};
  int tx_len [4] = '{5, 6, 7, 16};
  logic [4:0] rx_len [3] = '{5'h05, 5'h08, 5'h10};
  logic [15:0] rx_pat [3] = '{16'h8000, 16'hCCCC, 16'hA53C};
  logic [2:0] rx_exp [3] = '{3'b100, 3'b010, 3'b001};

  ilc_top #(.INTEG_CYCLES(2000)) dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .T1_MODE(T1_MODE),
    .TX_LOOP_EN(TX_LOOP_EN), .TX_FBIT_INS_DIS(TX_FBIT_INS_DIS),
    .TX_BIT_EN(TX_BIT_EN), .TX_FBIT_POS(TX_FBIT_POS),
    .TX_DATA_IN(TX_DATA_IN), .TX_DATA_OUT(TX_DATA_OUT),
    .RX_LINE_CLK(RX_LINE_CLK), .RX_LINE_DATA(RX_LINE_DATA),
    .LOOP_UP_DET(LOOP_UP_DET), .LOOP_DOWN_DET(LOOP_DOWN_DET),
    .SPARE_DET(SPARE_DET));
  ilc_line_model u_line (.clk(CLK_SYS), .rstn(RSTN), .en(line_en),
    .len(line_len), .pat(line_pat), .line_clk(RX_LINE_CLK),
    .line_data(RX_LINE_DATA));

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  // read data lands within one cycle of the strobe edge
  task automatic reg_rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    @(posedge CLK_SYS);
    #1 rd = REG_RDATA;
  endtask
  task automatic tx_bit(input logic fp, input logic d);
    @(posedge CLK_SYS);
    TX_BIT_EN <= 1'b1;
    TX_FBIT_POS <= fp;
    TX_DATA_IN <= d;
    @(posedge CLK_SYS);
    TX_BIT_EN <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************
  // clock, watchdog and tests
  // ****************************************************
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // the tests need about 18300 cycles
  initial begin
    repeat (40000) @(posedge CLK_SYS);
    errors++;
    $display("Error watchdog expired");
    give_verdict();
  end
  initial begin
    {RSTN, REG_WR, REG_RD, TX_LOOP_EN, TX_FBIT_INS_DIS} = '0;
    {TX_BIT_EN, TX_FBIT_POS, TX_DATA_IN, line_en} = '0;
    {REG_ADDR, REG_WDATA, line_len, line_pat} = '0;
    T1_MODE = 1'b1;
    repeat (8) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      reg_rd(8'hB6 + 8'(i));
      chk8("reset value", 8'h00, rd);
    end
    for (int i = 0; i < 11; i++) begin
      reg_wr(regs[i].a, regs[i].w);
      reg_rd(regs[i].a);
      chk8("register", regs[i].r, rd);
    end
    $display("test registers done");
    // last row sends 16 bits with framing insertion turned off
    for (int i = 0; i < 4; i++) begin
      tx_pat = tx_cd[i];
      reg_wr(8'hB6, tx_ctl[i]);
      reg_wr(8'hB7, tx_pat[15:8]);
      reg_wr(8'hB8, tx_pat[7:0]);
      TX_LOOP_EN <= 1'b0;
      TX_FBIT_INS_DIS <= (i == 3);
      tx_bit(1'b0, 1'b1);
      chk1("idle bit", 1'b1, TX_DATA_OUT);
      @(posedge CLK_SYS);
      TX_LOOP_EN <= 1'b1;
      for (int b = 0; b < 20; b++) begin
        p = tx_pat[15 - (b % tx_len[i])];
        f = (b == 9);
        tx_bit(f, ~p);
        chk1("tx bit", (f && i != 3) ? ~p : p,
             TX_DATA_OUT);
      end
    end
    $display("test transmit done");
    // up code 5 bits, down code 8 bits in both bytes, spare code 16 bits
    for (int i = 0; i < 3; i++) begin
      @(posedge CLK_SYS);
      line_len <= rx_len[i];
      line_pat <= rx_pat[i];
      line_en <= 1'b1;
      repeat (6000) @(posedge CLK_SYS);
      #1 chk1("up", rx_exp[i][2], LOOP_UP_DET);
      chk1("down", rx_exp[i][1], LOOP_DOWN_DET);
      chk1("spare", rx_exp[i][0], SPARE_DET);
      // host polls the status word while the code is still on the line
      reg_rd(8'hC0);
      chk8("status", {rx_exp[i][0], rx_exp[i][1],
        rx_exp[i][2], 5'h00}, rd);
      if (i == 0) begin
        reg_wr(8'hBA, 8'h00);
        repeat (2) @(posedge CLK_SYS);
        #1 chk1("restart", 1'b0, LOOP_UP_DET);
      end
    end
    $display("test detect done");
    @(posedge CLK_SYS);
    T1_MODE <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    #1 chk8("t1 off", 8'h00,
      {5'h00, LOOP_UP_DET, LOOP_DOWN_DET, SPARE_DET});
    $display("test mode done");
    // a reset in mid-run must clear the control register and the status again
    @(posedge CLK_SYS);
    RSTN <= 1'b0;
    T1_MODE <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    reg_rd(8'hB6);
    chk8("ctrl after reset", 8'h00, rd);
    reg_rd(8'hC0);
    chk8("status after reset", 8'h00, rd);
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_top
